// File: logic/kah_defs.svh
`ifndef KAH_DEFS_SVH
`define KAH_DEFS_SVH

// Host port addresses
`define KAH_ADDR_DATA      8'h54
`define KAH_ADDR_DIAG      8'h55
`define KAH_ADDR_HSHK      8'h56
`define KAH_ADDR_CTRL      8'h57
`define KAH_ADDR_ARST      8'h58

// Control and reset write values
`define KAH_CTRL_CONFIG    8'hC3
`define KAH_CTRL_IRQ_ON    8'h09
`define KAH_CTRL_IRQ_OFF   8'h08
`define KAH_ARST_ACTIVATE  8'h01
`define KAH_ARST_RELEASE   8'h00

// Handshake port bit positions
`define KAH_HS_OB_EMPTY    7
`define KAH_HS_IRQ_EN      6
`define KAH_HS_IB_FULL     5
`define KAH_HS_CONFIGURED  4
`define KAH_HS_IRQ         3
`define KAH_HS_ID_HI       2
`define KAH_HS_ID_LO       0

// Command field inside the high write byte
`define KAH_CMD_HI         12
`define KAH_CMD_LO         8
`define KAH_CMD_EXT        13

// Interrupt identifier of the self-test completion
`define KAH_ID_SELFTEST    3'h6

// Least adapter reset time
`define KAH_RST_MIN_NS     10000
`define KAH_CLK_NS         50
`define KAH_RST_MIN_CYC    ((`KAH_RST_MIN_NS + `KAH_CLK_NS - 1) / `KAH_CLK_NS)

`endif

// File: logic/kah_pkg.sv
package kah_pkg;

  // Byte from the microcontroller with its identifier
  typedef struct packed {
    logic [2:0] id;
    logic [7:0] data;
  } kah_ib_entry_t;

  // Byte and command from the host to the microcontroller
  typedef struct packed {
    logic       ext;
    logic [4:0] cmd;
    logic [7:0] data;
  } kah_ob_entry_t;

  typedef enum logic [1:0] {
    KAH_AR_HOLD,
    KAH_AR_ARMED,
    KAH_AR_RUN
  } kah_arst_state_t;

endpackage

// File: logic/kah_port.sv
`timescale 1ns/1ns
`include "kah_defs.svh"


module kah_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_reg;
  logic             push;
  logic             pop;

  assign push      = in_valid && ready_reg;
  assign pop       = out_valid && out_ready;
  assign in_ready  = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b1;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH[AW:0]);
    end
  end

  a_fifo_no_overfill: assert property (@(posedge ref_clk)
    disable iff (!arst_n) !ready_reg |-> count_reg == DEPTH[AW:0])
    else $error("fifo full flag without full count");
endmodule // kah_fifo

module kah_port #(
  parameter int FIFO_DEPTH  = 32,
  parameter int RST_MIN_CYC = `KAH_RST_MIN_CYC
) (
  // Clock, power-on reset and system reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       sys_reset,
  // Host I/O port
  input  wire logic [7:0] host_addr,
  input  wire logic [15:0] host_wdata,
  input  wire logic       io_write_strobe,
  input  wire logic       io_read_strobe,
  output logic      [7:0] host_rdata,
  output logic            host_irq,
  // Diagnostic sense input
  input  wire logic [7:0] diag_sense_port,
  // Microcontroller inbound side
  input  wire logic       ib_valid,
  output logic            ib_ready,
  input  wire logic [2:0] ib_id,
  input  wire logic [7:0] ib_data,
  // Microcontroller outbound side
  output logic            ob_valid,
  output logic      [7:0] ob_data,
  output logic      [4:0] ob_cmd,
  output logic            ob_cmd_ext,
  input  wire logic       ob_ack,
  // Microcontroller reset and status
  output logic            mcu_rst_n,
  output logic            selftest_posted
);
  kah_pkg::kah_ib_entry_t  fifo_in;
  kah_pkg::kah_ib_entry_t  fifo_out;
  kah_pkg::kah_ob_entry_t  ob_reg;
  kah_pkg::kah_ib_entry_t  ib_reg;
  kah_pkg::kah_arst_state_t ar_state_reg;
  logic                    fifo_out_valid;
  logic                    fifo_in_ready;
  logic                    ib_load;
  logic                    ib_full_reg;
  logic                    ob_full_reg;
  logic                    configured_reg;
  logic                    irq_en_reg;
  logic                    irq_reg;
  logic                    mcu_rst_n_reg;
  logic                    selftest_reg;
  logic [7:0]              rdata_reg;
  logic [7:0]              handshake_port;
  logic [15:0]             ar_cnt_reg;
  logic                    wr_data;
  logic                    wr_ctrl;
  logic                    wr_arst;
  logic                    rd_data;
  logic                    adapter_rst;

  assign wr_data = io_write_strobe && host_addr == `KAH_ADDR_DATA;
  assign wr_ctrl = io_write_strobe && host_addr == `KAH_ADDR_CTRL;
  assign wr_arst = io_write_strobe && host_addr == `KAH_ADDR_ARST;
  assign rd_data = io_read_strobe && host_addr == `KAH_ADDR_DATA;
  assign adapter_rst = (ar_state_reg != kah_pkg::KAH_AR_RUN);

  assign fifo_in.id   = ib_id;
  assign fifo_in.data = ib_data;

  // Inbound bytes queue here while the host has not read
  kah_fifo #(
    .WIDTH ($bits(kah_pkg::kah_ib_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_ib_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .flush     (adapter_rst),
    .in_valid  (ib_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (!ib_full_reg && configured_reg),
    .out_data  (fifo_out)
  );

  assign ib_ready = fifo_in_ready;
  assign ib_load  = fifo_out_valid && !ib_full_reg && configured_reg;

  // power-on, system reset or activate write
  // release honoured only after least hold time
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ar_state_reg <= kah_pkg::KAH_AR_HOLD;
      ar_cnt_reg   <= '0;
    end else if (sys_reset ||
                 (wr_arst && host_wdata[7:0] == `KAH_ARST_ACTIVATE)) begin
      ar_state_reg <= kah_pkg::KAH_AR_HOLD;
      ar_cnt_reg   <= '0;
    end else begin
      case (ar_state_reg)
        kah_pkg::KAH_AR_HOLD: begin
          if (ar_cnt_reg == 16'(RST_MIN_CYC - 1)) begin
            ar_state_reg <= kah_pkg::KAH_AR_ARMED;
          end else begin
            ar_cnt_reg <= ar_cnt_reg + 16'h0001;
          end
        end
        kah_pkg::KAH_AR_ARMED: begin
          if (wr_arst && host_wdata[7:0] == `KAH_ARST_RELEASE) begin
            ar_state_reg <= kah_pkg::KAH_AR_RUN;
          end
        end
        kah_pkg::KAH_AR_RUN: begin
          ar_state_reg <= kah_pkg::KAH_AR_RUN;
        end
        default: begin
          ar_state_reg <= kah_pkg::KAH_AR_HOLD;
        end
      endcase
    end
  end

  // controller held while adapter reset stands
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mcu_rst_n_reg <= 1'b0;
    end else begin
      mcu_rst_n_reg <= !adapter_rst;
    end
  end

  // configured flag only cleared at power-on; irq enable also cleared by control writes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      configured_reg <= 1'b0;
      irq_en_reg     <= 1'b0;
    end else if (wr_ctrl) begin
      if (host_wdata[7:0] == `KAH_CTRL_CONFIG) begin
        configured_reg <= 1'b1;
        irq_en_reg     <= 1'b0;
      end else if (host_wdata[7:0] == `KAH_CTRL_IRQ_ON) begin
        irq_en_reg <= configured_reg;
      end else if (host_wdata[7:0] == `KAH_CTRL_IRQ_OFF) begin
        irq_en_reg <= 1'b0;
      end
    end
  end

  // command bits latched with the byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ob_full_reg <= 1'b0;
      ob_reg      <= '0;
    end else if (wr_data && !ob_full_reg && configured_reg) begin
      ob_full_reg <= 1'b1;
      ob_reg.data <= host_wdata[7:0];
      ob_reg.cmd  <= host_wdata[`KAH_CMD_HI:`KAH_CMD_LO];
      ob_reg.ext  <= host_wdata[`KAH_CMD_EXT];
    end else if (ob_ack || adapter_rst) begin
      ob_full_reg <= 1'b0;
    end
  end

  // inbound buffer; load wins over read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ib_full_reg <= 1'b0;
      ib_reg      <= '0;
    end else if (ib_load) begin
      ib_full_reg <= 1'b1;
      ib_reg      <= fifo_out;
    end else if (rd_data) begin
      ib_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      selftest_reg <= 1'b0;
    end else if (adapter_rst) begin
      selftest_reg <= 1'b0;
    end else if (ib_load && fifo_out.id == `KAH_ID_SELFTEST) begin
      selftest_reg <= 1'b1;
    end
  end

  // bits 7 and 5 carry buffer handshake, 6 and 4 interface state
  // bits 2 to 0 show the inbound id
  always_comb begin
    handshake_port = '0;
    handshake_port[`KAH_HS_OB_EMPTY]   = !ob_full_reg;
    handshake_port[`KAH_HS_IRQ_EN]     = irq_en_reg;
    handshake_port[`KAH_HS_IB_FULL]    = ib_full_reg;
    handshake_port[`KAH_HS_CONFIGURED] = configured_reg;
    handshake_port[`KAH_HS_IRQ]        = irq_reg;
    handshake_port[`KAH_HS_ID_HI:`KAH_HS_ID_LO] = ib_reg.id;
  end

  // interrupt from a full inbound buffer
  // masking gates both the host request and handshake bit 3
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_en_reg && ib_full_reg && !rd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (io_read_strobe) begin
      case (host_addr)
        `KAH_ADDR_DATA: rdata_reg <= ib_reg.data;
        `KAH_ADDR_DIAG: rdata_reg <= diag_sense_port;
        `KAH_ADDR_HSHK: rdata_reg <= handshake_port;
        default:        rdata_reg <= '0;
      endcase
    end
  end

  assign host_rdata      = rdata_reg;
  assign host_irq        = irq_reg;
  assign ob_valid        = ob_full_reg;
  assign ob_data         = ob_reg.data;
  assign ob_cmd          = ob_reg.cmd;
  assign ob_cmd_ext      = ob_reg.ext;
  assign mcu_rst_n       = mcu_rst_n_reg;
  assign selftest_posted = selftest_reg;

  a_irq_masked: assert property (@(posedge ref_clk)
    disable iff (!arst_n) !irq_en_reg |=> !irq_reg)
    else $error("interrupt raised while masked");
  a_irq_raised: assert property (@(posedge ref_clk)
    disable iff (!arst_n) irq_en_reg && ib_full_reg && !rd_data |=> irq_reg)
    else $error("interrupt not raised on full inbound buffer");
  a_ob_latch_cmd: assert property (@(posedge ref_clk)
    disable iff (!arst_n) wr_data && !ob_full_reg && configured_reg |=>
      ob_full_reg && ob_cmd == $past(host_wdata[`KAH_CMD_HI:`KAH_CMD_LO]))
    else $error("command bits not latched with outbound byte");
  a_ob_refused: assert property (@(posedge ref_clk)
    disable iff (!arst_n) ob_full_reg |=> $stable(ob_data))
    else $error("full outbound buffer overwritten");
  a_ib_full_set: assert property (@(posedge ref_clk)
    disable iff (!arst_n) ib_load |=> handshake_port[`KAH_HS_IB_FULL])
    else $error("inbound full flag not set on load");
  a_hs_ob_empty: assert property (@(posedge ref_clk)
    disable iff (!arst_n) handshake_port[`KAH_HS_OB_EMPTY] == !ob_valid)
    else $error("handshake empty bit disagrees with buffer");
  a_rst_holds: assert property (@(posedge ref_clk)
    disable iff (!arst_n) ar_state_reg == kah_pkg::KAH_AR_HOLD && !wr_arst
      |=> !mcu_rst_n [*2])
    else $error("controller released without release write");
  a_cfg_survives: assert property (@(posedge ref_clk)
    disable iff (!arst_n) configured_reg && sys_reset |=> configured_reg)
    else $error("interface configuration lost on adapter reset");
  a_sys_reset: assert property (@(posedge ref_clk)
    disable iff (!arst_n) sys_reset |=> ##1 !mcu_rst_n)
    else $error("system reset did not hold controller");
  a_diag_read: assert property (@(posedge ref_clk)
    disable iff (!arst_n) io_read_strobe && host_addr == `KAH_ADDR_DIAG |=>
      host_rdata == $past(diag_sense_port))
    else $error("diagnostic sense read wrong");
endmodule // kah_port

// File: sim/kah_mcu_model.sv
`timescale 1ns/1ns

module kah_mcu_model #(
  parameter logic [7:0] CODE    = 8'hA5,
  parameter int         ACK_DLY = 6
) (
  // Clock and controller reset
  input  wire logic       ref_clk,
  input  wire logic       mcu_rst_n,
  // Inbound push
  output logic            ib_valid,
  input  wire logic       ib_ready,
  output logic      [2:0] ib_id,
  output logic      [7:0] ib_data,
  // Outbound take
  input  wire logic       ob_valid,
  input  wire logic [7:0] ob_data,
  input  wire logic [4:0] ob_cmd,
  output logic            ob_ack
);
  logic [10:0] q[$];
  logic [7:0]  last_data;
  logic [4:0]  last_cmd;
  logic        rst_q;
  int          wait_cnt;

  task automatic post(input logic [2:0] id, input logic [7:0] d);
    q.push_back({id, d});
  endtask

  initial begin
    {ib_valid, ib_id, ib_data, ob_ack, rst_q} = '0;
    wait_cnt = 0;
  end

  // Entry leaves once taken
  always @(posedge ref_clk) begin
    if (ib_valid && ib_ready) begin
      void'(q.pop_front());
    end
  end

  always @(negedge ref_clk) begin
    if (!mcu_rst_n) begin
      q.delete();
    end else if (!rst_q) begin
      q.push_back({3'h6, CODE});
    end
    rst_q = mcu_rst_n;
    if (q.size() > 0) begin
      ib_valid = 1'b1;
      {ib_id, ib_data} = q[0];
    end else begin
      ib_valid = 1'b0;
      {ib_id, ib_data} = ~{ib_id, ib_data};
    end
    if (ob_ack) begin
      ob_ack = 1'b0;
      wait_cnt = 0;
    end else if (ob_valid) begin
      wait_cnt++;
      if (wait_cnt >= ACK_DLY) begin
        ob_ack = 1'b1;
        last_data = ob_data;
        last_cmd = ob_cmd;
      end
    end
  end
endmodule // kah_mcu_model

// File: sim/testbench.sv
`timescale 1ns/1ns
`include "kah_defs.svh"

module testbench;
  localparam logic [7:0] CODE = 8'hA5;
  logic        ref_clk, arst_n, sys_reset;
  logic        io_write_strobe, io_read_strobe;
  logic [7:0]  host_addr, host_rdata, diag_sense_port, rdv;
  logic [15:0] host_wdata;
  logic        host_irq, ib_valid, ib_ready, ob_valid, ob_cmd_ext;
  logic        ob_ack, mcu_rst_n, selftest_posted;
  logic [2:0]  ib_id;
  logic [7:0]  ib_data, ob_data;
  logic [4:0]  ob_cmd;
  int          error_cnt, num_checks, i, k;

  kah_port dut_u (
    .ref_clk, .arst_n, .sys_reset, .host_addr, .host_wdata,
    .io_write_strobe, .io_read_strobe, .host_rdata, .host_irq,
    .diag_sense_port, .ib_valid, .ib_ready, .ib_id, .ib_data,
    .ob_valid, .ob_data, .ob_cmd, .ob_cmd_ext, .ob_ack,
    .mcu_rst_n, .selftest_posted);

  kah_mcu_model #(.CODE(CODE)) mcu_u (
    .ref_clk, .mcu_rst_n, .ib_valid, .ib_ready, .ib_id, .ib_data,
    .ob_valid, .ob_data, .ob_cmd, .ob_ack);

  always #25 ref_clk = ~ref_clk;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = d;
    io_write_strobe = 1'b1;
    @(negedge ref_clk);
    io_write_strobe = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    host_addr = a;
    io_read_strobe = 1'b1;
    @(negedge ref_clk);
    io_read_strobe = 1'b0;
    @(negedge ref_clk);
    rdv = host_rdata;
  endtask

  // Poll handshake port until all mask bits are set
  task automatic wait_hs(input logic [7:0] m);
    for (k = 0; k < 20; k++) begin
      rd(`KAH_ADDR_HSHK);
      if ((rdv & m) === m) break;
    end
    if ((rdv & m) !== m) begin
      error_cnt++;
      $display("unexpected at %0t: handshake poll timed out", $time);
    end
  endtask

  initial begin
    #(20000 * 50);
    error_cnt++;
    $display("unexpected at %0t: run timed out", $time);
    finish_test();
  end

  initial begin
    {ref_clk, arst_n, sys_reset, io_write_strobe, io_read_strobe} = '0;
    {host_addr, host_wdata, error_cnt, num_checks} = '0;
    diag_sense_port = 8'h5A;
    tick(16);
    arst_n = 1'b1;
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv, 8'h80);
    chk_bit(mcu_rst_n, 1'b0);
    rd(`KAH_ADDR_DIAG);
    chk_byte(rdv, 8'h5A);
    wr(`KAH_ADDR_CTRL, 16'h0009);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv, 8'h80);
    $display("test reset done");
    wr(`KAH_ADDR_CTRL, 16'h00C3);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv, 8'h90);
    wr(`KAH_ADDR_CTRL, 16'h0009);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv, 8'hD0);
    $display("test config done");
    wr(`KAH_ADDR_ARST, 16'h0001);
    wr(`KAH_ADDR_ARST, 16'h0000);
    tick(3);
    chk_bit(mcu_rst_n, 1'b0);
    tick(`KAH_RST_MIN_CYC + 5);
    wr(`KAH_ADDR_ARST, 16'h0000);
    tick(2);
    chk_bit(mcu_rst_n, 1'b1);
    for (k = 0; k < 20 && host_irq !== 1'b1; k++) tick(1);
    chk_bit(host_irq, 1'b1);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv, 8'hFE);
    chk_bit(selftest_posted, 1'b1);
    rd(`KAH_ADDR_DATA);
    chk_byte(rdv, CODE);
    tick(2);
    chk_bit(host_irq, 1'b0);
    $display("test release done");
    wr(`KAH_ADDR_CTRL, 16'h0008);
    mcu_u.post(3'h1, 8'h3C);
    tick(6);
    chk_bit(host_irq, 1'b0);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv & 8'hF7, 8'hB1);
    rd(`KAH_ADDR_DATA);
    chk_byte(rdv, 8'h3C);
    $display("test mask done");
    wait_hs(8'h80);
    chk_byte(rdv & 8'h80, 8'h80);
    wr(`KAH_ADDR_DATA, 16'h0141);
    chk_bit(ob_valid, 1'b1);
    chk_byte({3'h0, ob_cmd}, 8'h01);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv & 8'h80, 8'h00);
    wr(`KAH_ADDR_DATA, 16'h0222);
    chk_byte(ob_data, 8'h41);
    wait_hs(8'h80);
    chk_byte(mcu_u.last_data, 8'h41);
    chk_byte({3'h0, mcu_u.last_cmd}, 8'h01);
    wr(`KAH_ADDR_DATA, 16'h3F7E);
    chk_byte({ob_cmd_ext, 2'h0, ob_cmd}, 8'h9F);
    wait_hs(8'h80);
    $display("test outbound done");
    wr(`KAH_ADDR_CTRL, 16'h0009);
    for (i = 0; i < 34; i++) mcu_u.post(i[2:0], i[7:0]);
    for (k = 0; k < 100 && ib_ready !== 1'b0; k++) tick(1);
    chk_bit(ib_ready, 1'b0);
    for (i = 0; i < 34; i++) begin
      wait_hs(8'h20);
      chk_byte({5'h0, rdv[2:0]}, {5'h0, i[2:0]});
      rd(`KAH_ADDR_DATA);
      chk_byte(rdv, i[7:0]);
    end
    $display("test buffer done");
    tick(1);
    sys_reset = 1'b1;
    tick(1);
    sys_reset = 1'b0;
    tick(2);
    chk_bit(mcu_rst_n, 1'b0);
    rd(`KAH_ADDR_HSHK);
    chk_byte(rdv & 8'h50, 8'h50);
    tick(`KAH_RST_MIN_CYC + 5);
    wr(`KAH_ADDR_ARST, 16'h0000);
    tick(2);
    chk_bit(mcu_rst_n, 1'b1);
    $display("test system reset done");
    finish_test();
  end
endmodule // testbench
